// >>> core/omx_pkg.sv
// Constants and types for the serial-loaded output multiplexer port
// -----------------------------------------------------------------------
// Overview of operation
// - Switched outputs pass the input port pins straight through after power-up.
// - Force-zero input low drives every output, switched or not, to zero.
// - Write-protect high blocks any change to the stored output registers.
// - Path choice low: switched outputs from the selected source; high: pins.
// - Direct-bit latch is transparent while path choice low with a stored register selected, holds otherwise.
// - Direct-bit value is captured as path choice rises from zero to one.
// - Source select bits 7:6 reset to binary 10, the input port path.
// - A newly written source selection takes effect only at a bus STOP.
// - Select 00 is register A, 01 register B, 10 input port; 11 unused.
// - Stored bits 5 and 3:0 are switched data, bit 4 the direct bit.
// - One select pair exists; both stored registers write and read it.
// - Force high, path high: pins on switched outputs, direct from latch.
// - Capture register reads 000 above five pin bits and is read-only.
// - Pins are sampled into capture on first bus clock after each START.
// - START is SDA falling with SCL high; STOP is SDA rising with SCL high.
// - The block is a bus slave only and never drives the clock line.
// - Answer address 1001110 when address pick is one, 0110111 when zero.
// - The general call address is never acknowledged.
// - Register reads leave the stored registers and select pair unchanged.
// - Reads return register A, B, then capture; master may stop early.
// - Write byte: top two bits pick destination, low six the new value.
// - A written value reaches the stored register about 10 ms later.
// -----------------------------------------------------------------------
package omx_pkg;

    // -------------------------------------------------------------------
    // Bus addresses and register offsets
    // -------------------------------------------------------------------
    localparam logic [6:0] ADDR_PICK_HI = 7'h4e; // 1001 110
    localparam logic [6:0] ADDR_PICK_LO = 7'h37; // 0110 111
    localparam logic [1:0] REG_STORED_A = 2'h0;
    localparam logic [1:0] REG_STORED_B = 2'h1;
    localparam logic [1:0] REG_CAPTURE  = 2'h2;

    // -------------------------------------------------------------------
    // Field layout and select codes
    // -------------------------------------------------------------------
    localparam int         SEL_MSB      = 7;
    localparam int         SEL_LSB      = 6;
    localparam int         DIRECT_BIT   = 4;
    localparam logic [1:0] SEL_STORED_A = 2'h0;
    localparam logic [1:0] SEL_STORED_B = 2'h1;
    localparam logic [1:0] SEL_PORT     = 2'h2;
    localparam logic [1:0] SEL_UNUSED   = 2'h3;
    localparam logic [1:0] SEL_RESET    = SEL_PORT;
    localparam logic [5:0] STORED_RESET = 6'h00;
    localparam logic [2:0] CAPTURE_PAD  = 3'h0;
    localparam logic [3:0] BYTE_END     = 4'h8;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_FREQ_HZ    = 40_000_000;
    localparam int COMMIT_TIME_MS = 10;
    localparam int COMMIT_CYC     = CLK_FREQ_HZ / 1000 * COMMIT_TIME_MS;

    // Serial slave states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR,
        ST_WR_ACK,
        ST_RD,
        ST_RD_ACK
    } omx_state_e;

endpackage

// >>> core/omx_port.sv
// Serial slave, stored output registers and output multiplexer
`timescale 1ns/1ps
`default_nettype none
module omx_port
    import omx_pkg::*;
#(
    parameter int COMMIT_CYCLES = COMMIT_CYC, // Store commit delay
    parameter int CNT_W         = 20          // Commit timer width
)(
    input  wire logic       I_CLK,          // 40 MHz clock
    input  wire logic       I_RST_B,        // Async reset, active low
    input  wire logic       I_SCL,          // Bus clock in
    input  wire logic       I_SDA,          // Bus data in
    output logic            O_SDA,          // Bus data out, always 0
    output logic            O_SDA_OE_B,     // Low while pulling SDA
    input  wire logic [4:0] I_PORT,         // Input port pins
    input  wire logic       I_FORCE_ZERO_B, // Low forces outputs to 0
    input  wire logic       I_WP,           // Write protect
    input  wire logic       I_PATH_CHOICE,  // High selects pins
    input  wire logic       I_ADDR_PICK,    // Bus address pick
    output logic      [4:0] O_Y,            // Switched outputs
    output logic            O_DIRECT        // Unswitched direct bit
);

    // -------------------------------------------------------------------
    // Parameter checks
    // -------------------------------------------------------------------
    if (COMMIT_CYCLES < 1 || COMMIT_CYCLES >= (2 ** CNT_W)) begin : g_chk
        $error("COMMIT_CYCLES does not fit the commit timer");
    end

    // -------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------
    omx_state_e       state;
    logic             scl_q;
    logic             sda_q;
    logic       [3:0] cnt;
    logic       [7:0] shift;
    logic             rw;
    logic       [1:0] idx;
    logic             drive;
    logic             cap_pend;
    logic       [4:0] capture;
    logic       [5:0] stored_output_a;
    logic       [5:0] stored_output_b;
    logic       [1:0] sel;
    logic       [1:0] sel_pend;
    logic             sel_pv;
    logic             pend_v;
    logic             pend_dst;
    logic       [5:0] pend_dat;
    logic [CNT_W-1:0] timer;
    logic             latch;

    // Read byte for an index; select pair shared by both stores
    function automatic logic [7:0] rd_byte(
        input logic [1:0] i,
        input logic [1:0] s,
        input logic [5:0] a,
        input logic [5:0] b,
        input logic [4:0] c
    );
        logic [7:0] r;
        r = {CAPTURE_PAD, c};
        if (i == REG_STORED_A) begin
            r = {s, a};
        end else if (i == REG_STORED_B) begin
            r = {s, b};
        end
        return r;
    endfunction

    // -------------------------------------------------------------------
    // Bus condition detect
    // -------------------------------------------------------------------
    // Previous samples of the pins give edges and START/STOP
    wire scl_rise  = I_SCL & ~scl_q;
    wire scl_fall  = ~I_SCL & scl_q;
    wire start_det = I_SCL & scl_q & sda_q & ~I_SDA;
    wire stop_det  = I_SCL & scl_q & ~sda_q & I_SDA;

    // Address match; general call can never equal either address
    wire [6:0] own_addr = I_ADDR_PICK ? ADDR_PICK_HI : ADDR_PICK_LO;
    wire       addr_hit = (shift[7:1] == own_addr);
    wire       byte_end = (cnt == BYTE_END);

    // Index of the next byte to send, wrapping after the capture
    wire [1:0] idx_nx = (state == ST_ADDR_ACK || idx == REG_CAPTURE) ?
                        REG_STORED_A : idx + 2'h1;
    wire [7:0] tx_cur  = rd_byte(idx, sel, stored_output_a,
                                 stored_output_b, capture);
    wire [7:0] tx_next = rd_byte(idx_nx, sel, stored_output_a,
                                 stored_output_b, capture);

    // Completed write byte; protect drops it as the acknowledge starts, and the byte is still acknowledged
    wire       wr_end  = scl_fall & (state == ST_WR) & byte_end;
    wire       wr_take = wr_end & ~I_WP;
    wire [1:0] wr_dst  = shift[SEL_MSB:SEL_LSB];

    // Only a low is ever driven; the clock line has no output
    assign O_SDA      = 1'b0;
    assign O_SDA_OE_B = ~drive;

    // -------------------------------------------------------------------
    // Pin history
    // -------------------------------------------------------------------
    // Idle bus is high, so reset as high to avoid a false START
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= I_SCL;
            sda_q <= I_SDA;
        end
    end

    // -------------------------------------------------------------------
    // Serial slave state machine
    // -------------------------------------------------------------------
    // Sample on SCL rise, change SDA on SCL fall; reads touch no store
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state <= ST_IDLE;
            cnt   <= 4'h0;
            shift <= 8'h00;
            rw    <= 1'b0;
            idx   <= REG_STORED_A;
            drive <= 1'b0;
        end else if (start_det) begin
            state <= ST_ADDR;
            cnt   <= 4'h0;
            drive <= 1'b0;
        end else if (stop_det) begin
            state <= ST_IDLE;
            drive <= 1'b0;
        end else if (scl_rise) begin
            case (state)
                ST_ADDR, ST_WR: begin
                    shift <= {shift[6:0], I_SDA};
                    cnt   <= cnt + 4'h1;
                end
                ST_RD: cnt <= cnt + 4'h1;
                ST_RD_ACK: begin
                    if (I_SDA) begin
                        state <= ST_IDLE;
                    end
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state)
                ST_ADDR: begin
                    if (byte_end) begin
                        cnt <= 4'h0;
                        if (addr_hit) begin
                            state <= ST_ADDR_ACK;
                            drive <= 1'b1;
                            rw    <= shift[0];
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (rw) begin
                        state <= ST_RD;
                        idx   <= idx_nx;
                        drive <= ~tx_next[7];
                    end else begin
                        state <= ST_WR;
                        drive <= 1'b0;
                    end
                end
                ST_WR: begin
                    if (byte_end) begin
                        cnt   <= 4'h0;
                        state <= ST_WR_ACK;
                        drive <= 1'b1;
                    end
                end
                ST_WR_ACK: begin
                    state <= ST_WR;
                    drive <= 1'b0;
                end
                ST_RD: begin
                    if (byte_end) begin
                        cnt   <= 4'h0;
                        state <= ST_RD_ACK;
                        drive <= 1'b0;
                    end else begin
                        drive <= ~tx_cur[3'h7 - cnt[2:0]];
                    end
                end
                ST_RD_ACK: begin
                    state <= ST_RD;
                    idx   <= idx_nx;
                    drive <= ~tx_next[7];
                end
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Input capture
    // -------------------------------------------------------------------
    // Sampled per frame so a read always sees a fresh value
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            cap_pend <= 1'b0;
            capture  <= 5'h00;
        end else if (start_det) begin
            cap_pend <= 1'b1;
        end else if (cap_pend && scl_rise) begin
            cap_pend <= 1'b0;
            capture  <= I_PORT;
        end
    end

    // -------------------------------------------------------------------
    // Shared select pair
    // -------------------------------------------------------------------
    // Pending choice waits for STOP; a fresh write wins over the apply
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sel      <= SEL_RESET;
            sel_pend <= SEL_RESET;
            sel_pv   <= 1'b0;
        end else begin
            if (stop_det && sel_pv) begin
                sel    <= sel_pend;
                sel_pv <= 1'b0;
            end
            if (wr_take && wr_dst != SEL_UNUSED) begin
                sel_pend <= wr_dst;
                sel_pv   <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Delayed commit into the stored registers
    // -------------------------------------------------------------------
    // Models the slow store; a later write restarts the wait
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pend_v          <= 1'b0;
            pend_dst        <= 1'b0;
            pend_dat        <= STORED_RESET;
            timer           <= '0;
            stored_output_a <= STORED_RESET;
            stored_output_b <= STORED_RESET;
        end else if (wr_take && wr_dst <= SEL_STORED_B) begin
            pend_v   <= 1'b1;
            pend_dst <= wr_dst[0];
            pend_dat <= shift[5:0];
            timer    <= CNT_W'(COMMIT_CYCLES - 1);
        end else if (pend_v) begin
            if (timer != '0) begin
                timer <= timer - CNT_W'(1);
            end else begin
                pend_v <= 1'b0;
                if (!I_WP && !pend_dst) begin
                    stored_output_a <= pend_dat;
                end else if (!I_WP) begin
                    stored_output_b <= pend_dat;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Output multiplexer
    // -------------------------------------------------------------------
    // Unused code 11 falls back to the pins as the safe path
    wire [5:0] src_dat = (sel == SEL_STORED_A) ? stored_output_a :
                         stored_output_b;
    wire       src_nv  = (sel == SEL_STORED_A) || (sel == SEL_STORED_B);
    wire [4:0] nv_y    = {src_dat[5], src_dat[3:0]};
    wire next_latch = (!I_PATH_CHOICE && src_nv) ?
                      src_dat[DIRECT_BIT] : latch;
    wire [4:0] next_y = !I_FORCE_ZERO_B ? 5'h00 :
                        (I_PATH_CHOICE || !src_nv) ? I_PORT :
                        nv_y;

    // Registered outputs; one cycle from pin change to output
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            latch    <= 1'b0;
            O_Y      <= 5'h00;
            O_DIRECT <= 1'b0;
        end else begin
            latch    <= next_latch;
            O_Y      <= next_y;
            O_DIRECT <= I_FORCE_ZERO_B & next_latch;
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);

    sequence s_held;
        (I_PATH_CHOICE && I_FORCE_ZERO_B) [*2];
    endsequence
    sequence s_addr_done;
        scl_fall && state == ST_ADDR && byte_end;
    endsequence

    property p_force_zero;
        !I_FORCE_ZERO_B |=> (O_Y == 5'h00) && !O_DIRECT;
    endproperty
    a_force_zero: assert property (p_force_zero)
        else $error("outputs not zero under force");

    property p_path_pins;
        I_FORCE_ZERO_B && I_PATH_CHOICE |=> O_Y == $past(I_PORT);
    endproperty
    a_path_pins: assert property (p_path_pins)
        else $error("switched outputs do not follow pins");

    property p_hold;
        s_held |=> $stable(O_DIRECT);
    endproperty
    a_hold: assert property (p_hold)
        else $error("direct bit moved while latched");

    property p_sel_stop;
        !stop_det |=> $stable(sel);
    endproperty
    a_sel_stop: assert property (p_sel_stop)
        else $error("select changed without stop");

    property p_sel_apply;
        stop_det && sel_pv && !wr_take |=> sel == $past(sel_pend);
    endproperty
    a_sel_apply: assert property (p_sel_apply)
        else $error("pending select not applied at stop");

    property p_wp;
        I_WP |=> $stable(stored_output_a) && $stable(stored_output_b);
    endproperty
    a_wp: assert property (p_wp)
        else $error("stored value changed under protect");

    property p_capture;
        cap_pend && scl_rise && !start_det |=> capture == $past(I_PORT);
    endproperty
    a_capture: assert property (p_capture)
        else $error("pins not captured after start");

    property p_addr_ack;
        (s_addr_done and (!start_det && !stop_det)) |=>
            drive == $past(addr_hit);
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address acknowledge wrong");

    property p_no_gc;
        (s_addr_done and (shift[7:1] == 7'h00)) |=> !drive;
    endproperty
    a_no_gc: assert property (p_no_gc)
        else $error("general call acknowledged");

    // A commit still in flight or a STOP may legally move state
    property p_read_quiet;
        (state == ST_RD || state == ST_RD_ACK) && !pend_v && !stop_det |=>
            $stable(stored_output_a) && $stable(stored_output_b) &&
            $stable(sel) && $stable(sel_pend) && $stable(sel_pv);
    endproperty
    a_read_quiet: assert property (p_read_quiet)
        else $error("register read disturbed stored state");

endmodule
`default_nettype wire

// >>> dv/omx_master.sv
// Bus master model that drives the serial clock and data lines
`timescale 1ns/1ps
`default_nettype none
module omx_master (
    input  wire logic i_clk, // System clock
    input  wire logic i_sda, // Resolved data line
    output logic      o_scl, // Bus clock drive
    output logic      o_sda  // Data drive, 1 = released
);
    // --------------------------------
    // Idle bus
    // --------------------------------
    // Both lines rest high, as the pull-ups would hold them
    initial begin
        o_scl <= 1'b1;
        o_sda <= 1'b1;
    end

    // Four clocks per phase, above the slave's three-clock minimum
    task automatic hold();
        repeat (4) @(posedge i_clk);
    endtask

    // Data moves one clock after the clock falls, never while it is high
    task automatic bit_io(input logic b, output logic r);
        @(posedge i_clk);
        o_sda <= b;
        hold();
        o_scl <= 1'b1;
        hold();
        r = i_sda;
        o_scl <= 1'b0;
    endtask

    // Start, also usable as a repeated start from a low clock
    task automatic start();
        @(posedge i_clk);
        o_sda <= 1'b1;
        hold();
        o_scl <= 1'b1;
        hold();
        o_sda <= 1'b0;
        hold();
        o_scl <= 1'b0;
    endtask

    // Stop: data rises while the clock is high
    task automatic stop();
        @(posedge i_clk);
        o_sda <= 1'b0;
        hold();
        o_scl <= 1'b1;
        hold();
        o_sda <= 1'b1;
        hold();
    endtask

    // Address or data byte out MSB first, ninth clock for the answer
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask

    // Byte in; the last one is answered with a release
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule
`default_nettype wire

// >>> dv/omx_port_bench.sv
// Self-checking bench for the output multiplexer port
`timescale 1ns/1ps
`default_nettype none
module omx_port_bench import omx_pkg::*;;
    localparam int LIMIT = 20000; // Cycle ceiling for a hang
    logic       clk;
    logic       rst_b;
    logic       scl;
    logic       mst_sda;
    wire logic  sda;
    logic       sda_out;
    logic       sda_oe_b;
    logic [4:0] port;
    logic       force_b;
    logic       wp;
    logic       path;
    logic       pick;
    logic [4:0] y;
    logic       direct;
    int         n_errors = 0;
    int         total_checks = 0;
    int         cycles = 0;

    // Open-drain line: either party pulls low, pull-up otherwise
    assign sda = mst_sda & (sda_oe_b | sda_out);

    omx_port #(.COMMIT_CYCLES(8), .CNT_W(20)) i_dut (
        .I_CLK(clk), .I_RST_B(rst_b), .I_SCL(scl), .I_SDA(sda),
        .O_SDA(sda_out), .O_SDA_OE_B(sda_oe_b), .I_PORT(port),
        .I_FORCE_ZERO_B(force_b), .I_WP(wp), .I_PATH_CHOICE(path),
        .I_ADDR_PICK(pick), .O_Y(y), .O_DIRECT(direct));

    omx_master i_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(mst_sda));

    // --------------------------------
    // Clock and hang guard
    // --------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            finish_test();
        end
    end

    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Outputs read at the falling edge, clear of the launching edge
    task automatic outs(input logic [4:0] ey, input logic ed);
        @(negedge clk);
        check({3'h0, y}, {3'h0, ey});
        check({7'h0, direct}, {7'h0, ed});
    endtask

    // Commit timer is short here, so twenty clocks cover the store
    task automatic wr(input logic [6:0] a, input logic [7:0] d,
                      input logic ack_exp);
        logic ack;
        i_mst.start();
        i_mst.put({a, 1'b0}, ack);
        check({7'h0, ack}, {7'h0, ack_exp});
        if (ack) begin
            i_mst.put(d, ack);
            check({7'h0, ack}, 8'h01);
        end
        i_mst.stop();
        wait_clk(20);
    endtask

    task automatic rd(input logic [6:0] a, input int n,
                      input logic [7:0] e0, e1, e2);
        logic       ack;
        logic [7:0] d;
        logic [7:0] e [3];
        e = '{e0, e1, e2};
        i_mst.start();
        i_mst.put({a, 1'b1}, ack);
        check({7'h0, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            i_mst.get(i == n - 1, d);
            check(d, e[i]);
        end
        i_mst.stop();
        wait_clk(4);
    endtask

    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        rst_b <= 1'b0;
        port <= 5'h15;
        force_b <= 1'b1;
        wp <= 1'b0;
        path <= 1'b0;
        pick <= 1'b1;
        wait_clk(4);
        rst_b <= 1'b1;
        wait_clk(3);
        outs(5'h15, 1'b0);
        rd(ADDR_PICK_HI, 3, 8'h80, 8'h80, 8'h15);
        wr(ADDR_PICK_HI, 8'h3a, 1'b1);
        outs(5'h1a, 1'b1);
        @(posedge clk);
        path <= 1'b1;
        port <= 5'h0c;
        wait_clk(3);
        outs(5'h0c, 1'b1);
        // Selection moves to B while the direct bit must stay latched
        wr(ADDR_PICK_HI, 8'h45, 1'b1);
        outs(5'h0c, 1'b1);
        @(posedge clk);
        path <= 1'b0;
        wait_clk(3);
        outs(5'h05, 1'b0);
        rd(ADDR_PICK_HI, 3, 8'h7a, 8'h45, 8'h0c);
        rd(ADDR_PICK_HI, 1, 8'h7a, 8'h00, 8'h00);
        @(posedge clk);
        wp <= 1'b1;
        wr(ADDR_PICK_HI, 8'h3f, 1'b1);
        rd(ADDR_PICK_HI, 2, 8'h7a, 8'h45, 8'h00);
        outs(5'h05, 1'b0);
        @(posedge clk);
        wp <= 1'b0;
        wr(7'h00, 8'h80, 1'b0);
        wr(ADDR_PICK_LO, 8'h80, 1'b0);
        @(posedge clk);
        pick <= 1'b0;
        wr(ADDR_PICK_LO, 8'h80, 1'b1);
        outs(5'h0c, 1'b0);
        @(posedge clk);
        force_b <= 1'b0;
        wait_clk(3);
        outs(5'h00, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
